//--- lhc_pkg.sv
package lhc_pkg;
    localparam int          COL_W        = 7;
    localparam int          PAGE_W       = 2;
    localparam int          LINE_W       = 5;
    localparam logic [6:0]  COL_MAX      = 7'h4f;
    localparam int          MEM_DEPTH    = 320;
    localparam logic [7:0]  CMD_RMW      = 8'he0;
    localparam logic [7:0]  CMD_END      = 8'hee;
    localparam logic [7:0]  CMD_SWRST    = 8'he2;
    localparam logic [7:0]  CMD_DISP_HI  = 8'haf;
    localparam logic [7:0]  CMD_DISP_LO  = 8'hae;
    localparam logic [7:0]  CMD_MAP_LO   = 8'ha0;
    localparam logic [7:0]  CMD_MAP_HI   = 8'ha1;
    localparam logic [7:0]  CMD_PAGE     = 8'hb8;
    localparam logic [7:0]  CMD_PAGE_MSK = 8'hfc;
    localparam logic [7:0]  CMD_LINE     = 8'hc0;
    localparam logic [7:0]  CMD_LINE_MSK = 8'he0;
    localparam logic [1:0]  SWRST_PAGE   = 2'h3;
    localparam int          ST_BUSY      = 7;
    localparam int          ST_MAP       = 6;
    localparam int          ST_OFF       = 5;
    localparam int          ST_RST       = 4;
    localparam logic [3:0]  ST_LOW_ZERO  = 4'h0;
    localparam real         BUSY_NS      = 16.0;
    localparam real         CLK_NS       = 4.0;
    localparam int          BUSY_CYC     = int'($ceil(BUSY_NS / CLK_NS));
    localparam logic [3:0]  BUSY_CNT     = 4'(BUSY_CYC);
    localparam logic [3:0]  RST_CNT      = 4'h8;
    // Wishbone register offsets of the host controller
    localparam logic [3:0]  WB_CMD       = 4'h0;
    localparam logic [3:0]  WB_DATA      = 4'h4;
    localparam logic [3:0]  WB_STAT      = 4'h8;
    localparam logic [3:0]  WB_RDATA     = 4'hc;
    // Host operation kinds
    localparam logic [1:0]  OP_CMD       = 2'h0;
    localparam logic [1:0]  OP_WDATA     = 2'h1;
    localparam logic [1:0]  OP_RDATA     = 2'h2;
    localparam logic [1:0]  OP_RSTAT     = 2'h3;
endpackage

//--- lhc_if.sv
`timescale 1ns/1ps
// Parallel byte bus between host and display device
interface lhc_if;
    logic       cmd_data_sel;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] host_byte_lines_o_host;
    logic       host_byte_lines_oe_host;
    logic [7:0] host_byte_lines_o_dev;
    logic       host_byte_lines_oe_dev;
    logic [7:0] host_byte_lines;

    // Resolved bus level; undriven lines read as zero
    assign host_byte_lines = host_byte_lines_oe_dev ?
        host_byte_lines_o_dev :
        (host_byte_lines_oe_host ? host_byte_lines_o_host : 8'h00);

    modport host (
        output cmd_data_sel,
        output rd_n,
        output wr_n,
        output host_byte_lines_o_host,
        output host_byte_lines_oe_host,
        input  host_byte_lines
    );
    modport dev (
        input  cmd_data_sel,
        input  rd_n,
        input  wr_n,
        output host_byte_lines_o_dev,
        output host_byte_lines_oe_dev,
        input  host_byte_lines
    );
endinterface

//--- lhc_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a bundle of pin levels
module lhc_sync #(parameter int W = 1) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second; reset shows the idle pin levels
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= rst_val_i;
            q_o     <= rst_val_i;
        end
        else
        begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule

//--- lhc_dev.sv
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Display device end: status, memory port, read-modify-write
module lhc_dev
    import lhc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    lhc_if.dev              bus,
    output logic [1:0]      page_o,
    output logic [6:0]      column_o,
    output logic [4:0]      start_line_o,
    output logic            display_on_o,
    output logic            seg_reversed_o,
    output logic            rmw_mode_o
);
    logic [7:0] mem [0:MEM_DEPTH-1];
    logic [10:0] pin_s;
    logic [10:0] pin_prev_ff;
    logic       sel_s, rd_n_s, wr_n_s;
    logic [7:0] byte_s;
    logic       rd_fall, wr_rise;
    logic [3:0] busy_cnt_ff;
    logic [3:0] rst_cnt_ff;
    logic       resetting;
    logic [7:0] latch_ff;
    logic [7:0] drive_ff;
    logic       drive_en_ff;
    logic [6:0] col_save_ff;
    logic [1:0] page_ff;
    logic [6:0] col_ff;
    logic [4:0] line_ff;
    logic       disp_on_ff, map_ff, rmw_ff;

    // Column step with wrap
    function automatic logic [6:0] col_inc(input logic [6:0] c);
        col_inc = (c == COL_MAX) ? 7'h00 : 7'(c + 7'h01);
    endfunction

    // Memory cell index: each page holds one full row of columns
    function automatic logic [8:0] mem_addr(input logic [1:0] p,
                                            input logic [6:0] c);
        mem_addr = 9'({7'h00, p} * (9'(COL_MAX) + 9'h001)) + {2'h0, c};
    endfunction

    // Masked match for command codes that carry an argument
    function automatic logic cmd_hit(input logic [7:0] b,
                                     input logic [7:0] code,
                                     input logic [7:0] msk);
        cmd_hit = ((b & msk) == code);
    endfunction

    // Pins pass two flops; reset shows both strobes idle high
    lhc_sync #(.W(11)) u_sync (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .d_i       ({bus.cmd_data_sel, bus.rd_n, bus.wr_n,
                     bus.host_byte_lines}),
        .rst_val_i (11'h300),
        .q_o       (pin_s)
    );
    assign {sel_s, rd_n_s, wr_n_s, byte_s} = pin_s;

    // Strobe edges: read acts on falling edge, write on rising edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_prev_ff <= 11'h300; // Idle strobes, so no false edge
        else
            pin_prev_ff <= pin_s;
    end
    // Edge flags, each true for one cycle per strobe
    assign rd_fall = pin_prev_ff[9] & ~rd_n_s & wr_n_s;
    assign wr_rise = ~pin_prev_ff[8] & wr_n_s & rd_n_s;
    assign resetting = (rst_cnt_ff != 4'h0);

    // Reset in progress window after hardware reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rst_cnt_ff <= RST_CNT;
        else if (resetting)
            rst_cnt_ff <= rst_cnt_ff - 4'h1;
    end

    // Busy time after each accepted command or data access
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            busy_cnt_ff <= 4'h0;
        else if (wr_rise || (rd_fall && sel_s))
            busy_cnt_ff <= BUSY_CNT;
        else if (busy_cnt_ff != 4'h0)
            busy_cnt_ff <= busy_cnt_ff - 4'h1;
    end

    // Byte bus drive during reads
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            drive_ff    <= 8'h00;
            drive_en_ff <= 1'b0;
        end
        else if (rd_fall && !sel_s)
        begin
            drive_ff    <= {resetting || busy_cnt_ff != 4'h0,
                            map_ff,
                            ~disp_on_ff,
                            resetting,
                            ST_LOW_ZERO};
            drive_en_ff <= 1'b1;
        end
        else if (rd_fall && sel_s)
        begin
            drive_ff    <= latch_ff;
            drive_en_ff <= 1'b1;
        end
        else if (rd_n_s)
            drive_en_ff <= 1'b0;
    end
    // Enable also follows the raw strobe so the lines free up at once
    assign bus.host_byte_lines_o_dev  = drive_ff;
    assign bus.host_byte_lines_oe_dev = drive_en_ff & ~bus.rd_n;

    // Memory write straight from the bus and read into output latch
    always_ff @(posedge clk_i)
    begin
        if (wr_rise && sel_s && !resetting)
            mem[mem_addr(page_ff, col_ff)] <= byte_s;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            latch_ff <= 8'h00;
        else if (rd_fall && sel_s && !resetting)
            latch_ff <= mem[mem_addr(page_ff, col_ff)];
    end

    // Column pointer, mode and saved column
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            col_ff      <= 7'h00;
            col_save_ff <= 7'h00;
            rmw_ff      <= 1'b0;
        end
        else if (!resetting)
        begin
            if (wr_rise && sel_s)
                col_ff <= col_inc(col_ff);
            else if (rd_fall && sel_s && !rmw_ff)
                col_ff <= col_inc(col_ff);
            else if (wr_rise && !sel_s && byte_s == CMD_RMW)
            begin
                col_save_ff <= col_ff;
                rmw_ff      <= 1'b1;
            end
            else if (wr_rise && !sel_s && byte_s == CMD_END)
            begin
                col_ff <= col_save_ff;
                rmw_ff <= 1'b0;
            end
            // Column set command is frozen in read-modify-write mode
            else if (wr_rise && !sel_s && !byte_s[7] && !rmw_ff)
                col_ff <= (byte_s[6:0] > COL_MAX) ? COL_MAX : byte_s[6:0];
        end
    end

    // Other registers stay writable in any mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            page_ff    <= 2'h0;
            line_ff    <= 5'h00;
            disp_on_ff <= 1'b0;
            map_ff     <= 1'b0;
        end
        else if (wr_rise && !sel_s && !resetting)
        begin
            if (byte_s == CMD_SWRST)
            begin
                line_ff <= 5'h00;
                page_ff <= SWRST_PAGE;
            end
            else if (cmd_hit(byte_s, CMD_PAGE, CMD_PAGE_MSK))
                page_ff <= byte_s[1:0];
            else if (cmd_hit(byte_s, CMD_LINE, CMD_LINE_MSK))
                line_ff <= byte_s[4:0];
            else if (byte_s == CMD_DISP_HI)
                disp_on_ff <= 1'b1;
            else if (byte_s == CMD_DISP_LO)
                disp_on_ff <= 1'b0;
            else if (byte_s == CMD_MAP_HI)
                map_ff <= 1'b1;
            else if (byte_s == CMD_MAP_LO)
                map_ff <= 1'b0;
        end
    end

    // Register levels out to the rest of the chip
    assign page_o         = page_ff;
    assign column_o       = col_ff;
    assign start_line_o   = line_ff;
    assign display_on_o   = disp_on_ff;
    assign seg_reversed_o = map_ff;
    assign rmw_mode_o     = rmw_ff;
endmodule

//--- lhc_host.sv
`timescale 1ns/1ps
// Host end: Wishbone slave that runs byte bus cycles
module lhc_host
    import lhc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    lhc_if.host              bus
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_POLL  = 3'b001,
        S_PWAIT = 3'b010,
        S_STRB  = 3'b011,
        S_HOLD  = 3'b100,
        S_GAP   = 3'b101
    } lhc_state_t;

    lhc_state_t state_ff;
    logic [1:0] op_ff;
    logic [7:0] wbyte_ff;
    logic [7:0] rbyte_ff;
    logic [7:0] stat_ff;
    logic       busy_op_ff;
    logic [3:0] tmr_ff;
    logic [7:0] bus_s;
    logic       req;
    logic       sel_ff, rd_n_ff, wr_n_ff, oe_ff;

    lhc_sync #(.W(8)) u_sync (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .d_i       (bus.host_byte_lines),
        .rst_val_i (8'h00),
        .q_o       (bus_s)
    );

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Wishbone answer: writes start an operation, reads show state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            case (wb_adr_i)
                WB_STAT:  wb_dat_o <= {23'h0, busy_op_ff, stat_ff};
                WB_RDATA: wb_dat_o <= {24'h0, rbyte_ff};
                default:  wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Sequencer: poll status until ready, then strobe the transfer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff   <= S_IDLE;
            busy_op_ff <= 1'b0;
            op_ff      <= OP_CMD;
            wbyte_ff   <= 8'h00;
            rbyte_ff   <= 8'h00;
            stat_ff    <= 8'h00;
            tmr_ff     <= 4'h0;
            sel_ff     <= 1'b0;
            rd_n_ff    <= 1'b1;
            wr_n_ff    <= 1'b1;
            oe_ff      <= 1'b0;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                begin
                    if (req && wb_we_i && wb_sel_i[0] && !busy_op_ff)
                    begin
                        busy_op_ff <= 1'b1;
                        wbyte_ff   <= wb_dat_i[7:0];
                        case (wb_adr_i)
                            WB_CMD:   op_ff <= OP_CMD;
                            WB_DATA:  op_ff <= OP_WDATA;
                            WB_RDATA: op_ff <= OP_RDATA;
                            default:  op_ff <= OP_RSTAT;
                        endcase
                        state_ff <= S_POLL;
                    end
                end
                S_POLL:
                begin
                    sel_ff   <= 1'b0;
                    rd_n_ff  <= 1'b0;
                    tmr_ff   <= 4'h6;
                    state_ff <= S_PWAIT;
                end
                S_PWAIT:
                begin
                    tmr_ff <= tmr_ff - 4'h1;
                    if (tmr_ff == 4'h0)
                    begin
                        rd_n_ff <= 1'b1;
                        stat_ff <= bus_s;
                        if (bus_s[ST_BUSY])
                            state_ff <= S_GAP;
                        else if (op_ff == OP_RSTAT)
                        begin
                            busy_op_ff <= 1'b0;
                            state_ff   <= S_IDLE;
                        end
                        else
                            state_ff <= S_STRB;
                    end
                end
                S_STRB:
                begin
                    sel_ff  <= (op_ff != OP_CMD);
                    rd_n_ff <= (op_ff != OP_RDATA);
                    wr_n_ff <= (op_ff == OP_RDATA);
                    oe_ff   <= (op_ff != OP_RDATA);
                    tmr_ff  <= 4'h6;
                    state_ff <= S_HOLD;
                end
                S_HOLD:
                begin
                    tmr_ff <= tmr_ff - 4'h1;
                    if (tmr_ff == 4'h0)
                    begin
                        if (op_ff == OP_RDATA)
                            rbyte_ff <= bus_s; // first is dummy
                        rd_n_ff    <= 1'b1;
                        wr_n_ff    <= 1'b1;
                        busy_op_ff <= 1'b0;
                        state_ff   <= S_IDLE;
                    end
                end
                S_GAP:
                    state_ff <= S_POLL;
                default:
                    state_ff <= S_IDLE;
            endcase
            if (state_ff == S_IDLE)
                oe_ff <= 1'b0;
        end
    end

    assign bus.cmd_data_sel            = sel_ff;
    assign bus.rd_n                    = rd_n_ff;
    assign bus.wr_n                    = wr_n_ff;
    assign bus.host_byte_lines_o_host  = wbyte_ff;
    assign bus.host_byte_lines_oe_host = oe_ff;
endmodule

//--- lhc_assertions.sv
`timescale 1ns/1ps
// Watches the parallel byte bus between host end and device end
module lhc_assertions (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       cmd_data_sel,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       host_byte_lines_oe_host,
    input  wire logic [7:0] host_byte_lines_o_dev,
    input  wire logic       host_byte_lines_oe_dev
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Device drives a status byte
    wire stat_rd = host_byte_lines_oe_dev && !cmd_data_sel;

    // Read strobe starts, device answers within a few cycles
    sequence s_rd_start;
        $fell(rd_n);
    endsequence
    sequence s_dev_answer;
        ##[1:8] host_byte_lines_oe_dev;
    endsequence

    property p_rd_answer;
        s_rd_start |-> (!rd_n throughout s_dev_answer);
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("device did not answer read strobe");
    property p_oe_gate;
        host_byte_lines_oe_dev |-> wr_n;
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("device drives bus during write strobe");
    property p_low_zero;
        stat_rd |-> host_byte_lines_o_dev[3:0] == 4'h0;
    endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("status low nibble not zero");
    property p_no_clash;
        !(host_byte_lines_oe_dev && host_byte_lines_oe_host);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the bus");
    property p_one_strobe;
        !(!rd_n && !wr_n);
    endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("read and write strobes low together");
    property p_wr_drive;
        !wr_n |-> host_byte_lines_oe_host;
    endproperty
    a_wr_drive: assert property (p_wr_drive)
        else $error("host not driving during write strobe");
    property p_wr_hold;
        $fell(wr_n) |-> (!wr_n) [*4];
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write strobe too short");
    property p_stat_stable;
        stat_rd && $past(stat_rd) |-> $stable(host_byte_lines_o_dev[6:4]);
    endproperty
    a_stat_stable: assert property (p_stat_stable)
        else $error("status flags moved during a read");
    property p_rst_busy;
        stat_rd && host_byte_lines_o_dev[4] |-> host_byte_lines_o_dev[7];
    endproperty
    a_rst_busy: assert property (p_rst_busy)
        else $error("reset flag shown without busy flag");
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
// Drives the host end over Wishbone, device end faces it on the bus
module testbench;
    import lhc_pkg::*;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, disp, segr, rmw;
    logic [3:0]  wb_adr, wb_sel;
    logic [31:0] wb_dat, wb_dat_o, wb_rd;
    logic [1:0]  page, pg;
    logic [6:0]  col;
    logic [4:0]  line;
    logic [7:0]  b [3];
    logic [7:0]  exp_q [$];
    logic [7:0]  e;
    int          bad_count, comparisons, cyc_cnt;
    integer      seed = 32'h1b95;

    lhc_if bus_if ();
    lhc_host lhc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack), .bus(bus_if));
    lhc_dev lhc_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if),
        .page_o(page), .column_o(col), .start_line_o(line),
        .display_on_o(disp), .seg_reversed_o(segr), .rmw_mode_o(rmw));
    lhc_assertions lhc_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
        .cmd_data_sel(bus_if.cmd_data_sel), .rd_n(bus_if.rd_n),
        .wr_n(bus_if.wr_n),
        .host_byte_lines_oe_host(bus_if.host_byte_lines_oe_host),
        .host_byte_lines_o_dev(bus_if.host_byte_lines_o_dev),
        .host_byte_lines_oe_dev(bus_if.host_byte_lines_oe_dev));

    // Clock
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // One classic Wishbone cycle
    task automatic wb(input logic       we,
                      input logic [3:0] a,
                      input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_sel <= 4'h1;
        wb_adr <= a;
        wb_dat <= {24'h00_0000, d};
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        wb_rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    // Start an operation, poll until done, then let the device settle
    task automatic op(input logic [3:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
        do wb(1'b0, WB_STAT, 8'h00); while (wb_rd[8] !== 1'b0);
        repeat (10) @(posedge clk_i);
    endtask

    // Start a read, note the expected byte, fetch the result
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] x);
        op(a, 8'h00);
        exp_q.push_back(x);
        wb(1'b0, a, 8'h00);
    endtask

    task final_report;
        $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Compares read results against the oldest note
    always @(posedge clk_i)
    begin
        if (wb_ack === 1'b1 && !wb_we && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            `CHK(wb_dat_o[7:0], e)
        end
    end

    // Cuts a hang short
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            bad_count++;
            final_report();
        end
    end

    initial
    begin
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // First request at once, so the first poll meets the reset window
        // Status flags for each display and mapping setting
        for (int i = 0; i < 4; i++)
        begin
            op(WB_CMD, i[0] ? CMD_DISP_HI : CMD_DISP_LO);
            op(WB_CMD, i[1] ? CMD_MAP_HI : CMD_MAP_LO);
            chk_rd(WB_STAT, {1'b0, i[1], !i[0], 1'b0, ST_LOW_ZERO});
            `CHK(segr, i[1])
        end
        $display("status test done");
        // Writes across the column wrap, then read back after a dummy
        pg = 2'($random(seed));
        op(WB_CMD, CMD_PAGE | {6'h00, pg});
        op(WB_CMD, 8'h4e);
        for (int i = 0; i < 3; i++)
        begin
            b[i] = 8'($random(seed));
            op(WB_DATA, b[i]);
        end
        `CHK(col, 7'h01)
        `CHK(page, pg)
        op(WB_CMD, 8'h4e);
        op(WB_RDATA, 8'h00);
        for (int i = 0; i < 3; i++)
            chk_rd(WB_RDATA, b[i]);
        `CHK(col, 7'h02)
        $display("data test done");
        // Read-modify-write: reads hold column, end restores it
        op(WB_CMD, 8'h0a);
        op(WB_CMD, CMD_RMW);
        `CHK(rmw, 1'b1)
        op(WB_RDATA, 8'h00);
        op(WB_RDATA, 8'h00);
        `CHK(col, 7'h0a)
        op(WB_DATA, 8'h5a);
        `CHK(col, 7'h0b)
        op(WB_CMD, CMD_PAGE | {6'h00, ~pg});
        `CHK(page, ~pg)
        op(WB_CMD, CMD_PAGE | {6'h00, pg});
        op(WB_CMD, CMD_END);
        `CHK(rmw, 1'b0)
        `CHK(col, 7'h0a)
        op(WB_RDATA, 8'h00);
        chk_rd(WB_RDATA, 8'h5a);
        $display("rmw test done");
        // Software reset touches only start line and page
        op(WB_CMD, CMD_LINE | 8'h05);
        `CHK(line, 5'h05)
        op(WB_CMD, CMD_SWRST);
        `CHK(line, 5'h00)
        `CHK(page, SWRST_PAGE)
        `CHK(col, 7'h0c)
        `CHK(disp, 1'b1)
        $display("reset test done");
        final_report();
    end
endmodule
